// >>> src/dpw_pkg.sv
// Shared constants for the addressable wiper register bank.
// Assumes a single 25 MHz system clock and a 2-wire bus sampled by it.
package dpw_pkg;
	// ------------------------------------------------------------
	// Widths and reset values
	// ------------------------------------------------------------
	localparam int        REG_W         = 8;
	localparam int        TAP_COUNT     = 256;
	localparam int        SEL_W         = 3;
	localparam logic [7:0] STORE_RESET  = 8'h00;
	localparam logic [7:0] WIPER_RESET  = 8'h00;
	// ------------------------------------------------------------
	// Control byte layout: code, select bits, direction
	// ------------------------------------------------------------
	localparam logic [3:0] CTRL_CODE    = 4'h5;
	localparam int        CODE_MSB      = 7;
	localparam int        CODE_LSB      = 4;
	localparam int        SEL_MSB       = 3;
	localparam int        SEL_LSB       = 1;
	localparam int        DIR_BIT       = 0;
	// ------------------------------------------------------------
	// Write command bytes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_WR_STORE = 8'ha9;
	localparam logic [7:0] CMD_WR_WIPER = 8'haa;
	localparam logic [7:0] CMD_WR_BOTH  = 8'haf;
	// ------------------------------------------------------------
	// Input synchroniser: scl, sda, select[2:0]; bus idles high
	// ------------------------------------------------------------
	localparam int        SYNC_W        = 5;
	localparam logic [4:0] SYNC_INIT    = 5'h18;
	localparam int        SYNC_SCL      = 4;
	localparam int        SYNC_SDA      = 3;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// Serial transfer states, one-hot
	typedef enum logic [8:0] {
		ST_IDLE      = 9'h001,
		ST_ADDR      = 9'h002,
		ST_ADDR_ACK  = 9'h004,
		ST_CMD       = 9'h008,
		ST_CMD_ACK   = 9'h010,
		ST_WDATA     = 9'h020,
		ST_WDATA_ACK = 9'h040,
		ST_RDATA     = 9'h080,
		ST_RACK      = 9'h100
	} dpw_state_t;
endpackage

// >>> src/dpw_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs asynchronous to clock_in; output changes once stages two and three agree.
`timescale 1ns/1ns
module dpw_sync3 #(
	parameter int              WIDTH = 5,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input  wire logic             clock_in,  // System clock
	input  wire logic             rst_in,    // Async reset, active high
	input  wire logic [WIDTH-1:0] raw_in,    // Pins from outside the domain
	output logic      [WIDTH-1:0] level_out  // Filtered levels
);
	// Refuse widths the filter cannot hold, at elaboration
	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("dpw_sync3: WIDTH must be at least 1");
		end
	endgenerate

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_level;

	// Accept a new level per bit only when the last two stages agree
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			always_comb begin
				next_level[gi] = (stage2[gi] == stage3[gi]) ? stage3[gi] : level_out[gi];
			end
		end
	endgenerate

	// Shift chain and filtered output
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			stage1    <= INIT;
			stage2    <= INIT;
			stage3    <= INIT;
			level_out <= INIT;
		end else begin
			stage1    <= raw_in;
			stage2    <= stage1;
			stage3    <= stage2;
			level_out <= next_level;
		end
	end
endmodule

// >>> src/dpw_wiper_regs.sv
// Register bank and 2-wire slave of a 256-tap digital potentiometer.
// Assumes scl/sda sampled by clock_in (much faster than scl); sda is open drain.
`timescale 1ns/1ns
// Contract
// - Two 8-bit registers exist; the storage byte has no effect on the wiper.
// - The wiper register selects exactly one of 256 taps and the tap follows it directly.
// - Decoding is monotonic; 00h is the low-end terminal and FFh one step below the high end.
// - On power-up the wiper register is 00h.
// - The bus address comes from the three select inputs; only that address is answered.
// - The wiper register is writable and readable, and a read returns the live value.
// - The address byte is code 0101, three select bits, direction; ack only on full match.
// - Direction one is a read from the device, zero a write to it.
// - A read returns the storage byte first, then the wiper byte; the master may stop after either.
// - All bytes travel most significant bit first.
module dpw_wiper_regs (
	input  wire logic                          clock_in,         // 25 MHz system clock
	input  wire logic                          rst_in,           // Power-up reset, async, high
	input  wire logic                          scl_in,           // Bus clock from master
	input  wire logic                          sda_in,           // Bus data level
	output logic                               sda_out,          // Data driven value (low)
	output logic                               sda_drive_n_out,  // Low while driving sda
	input  wire logic                          addr_select_bit0, // Address select input 0
	input  wire logic                          addr_select_bit1, // Address select input 1
	input  wire logic                          addr_select_bit2, // Address select input 2
	output logic [dpw_pkg::REG_W-1:0]          storage_out,      // General storage byte
	output logic [dpw_pkg::REG_W-1:0]          wiper_out,        // Wiper position register
	output logic [dpw_pkg::TAP_COUNT-1:0]      tap_select_out    // One-hot tap, bit0 = low end
);
	// ------------------------------------------------------------
	// Input conditioning
	// ------------------------------------------------------------
	logic [dpw_pkg::SYNC_W-1:0] pins;
	logic                       scl_q;
	logic                       sda_q;

	dpw_sync3 #(
		.WIDTH (dpw_pkg::SYNC_W),
		.INIT  (dpw_pkg::SYNC_INIT)
	) u_sync (
		.clock_in  (clock_in),
		.rst_in    (rst_in),
		.raw_in    ({scl_in, sda_in, addr_select_bit2, addr_select_bit1, addr_select_bit0}),
		.level_out (pins)
	);

	logic [dpw_pkg::SEL_W-1:0] sel_pins;
	logic                      scl_rise;
	logic                      scl_fall;
	logic                      bus_start;
	logic                      bus_stop;

	// Bus events from filtered levels and their previous values
	always_comb begin
		sel_pins  = pins[dpw_pkg::SEL_W-1:0];
		scl_rise  = pins[dpw_pkg::SYNC_SCL] && !scl_q;
		scl_fall  = !pins[dpw_pkg::SYNC_SCL] && scl_q;
		bus_start = scl_q && pins[dpw_pkg::SYNC_SCL] && sda_q && !pins[dpw_pkg::SYNC_SDA];
		bus_stop  = scl_q && pins[dpw_pkg::SYNC_SCL] && !sda_q && pins[dpw_pkg::SYNC_SDA];
	end

	// ------------------------------------------------------------
	// Transfer state
	// ------------------------------------------------------------
	dpw_pkg::dpw_state_t state;
	dpw_pkg::dpw_state_t next_state;
	logic [3:0]          bit_cnt;
	logic [3:0]          next_bit_cnt;
	logic [7:0]          shift;
	logic [7:0]          next_shift;
	logic [7:0]          cmd;
	logic [7:0]          next_cmd;
	logic                drive_low;
	logic                next_drive_low;
	logic                rd_second;
	logic                next_rd_second;
	logic                master_ack;
	logic                next_master_ack;
	logic [7:0]          next_storage;
	logic [7:0]          next_wiper;
	logic [dpw_pkg::TAP_COUNT-1:0] next_tap;
	logic                addr_match;

	// Control byte match against code and live select pins
	always_comb begin
		addr_match = (shift[dpw_pkg::CODE_MSB:dpw_pkg::CODE_LSB] == dpw_pkg::CTRL_CODE) &&
			(shift[dpw_pkg::SEL_MSB:dpw_pkg::SEL_LSB] == sel_pins);
	end

	// One-hot tap decode of the wiper register, monotonic in value
	genvar gt;
	generate
		for (gt = 0; gt < dpw_pkg::TAP_COUNT; gt++) begin : g_tap
			always_comb begin
				next_tap[gt] = (next_wiper == 8'(gt));
			end
		end
	endgenerate

	// Next-state logic of the serial slave and the registers
	always_comb begin
		next_state      = state;
		next_bit_cnt    = bit_cnt;
		next_shift      = shift;
		next_cmd        = cmd;
		next_drive_low  = drive_low;
		next_rd_second  = rd_second;
		next_master_ack = master_ack;
		next_storage    = storage_out;
		next_wiper      = wiper_out;
		if (bus_stop) begin
			next_state     = dpw_pkg::ST_IDLE;
			next_drive_low = 1'b0;
		end else if (bus_start) begin
			next_state     = dpw_pkg::ST_ADDR;
			next_bit_cnt   = 4'h0;
			next_drive_low = 1'b0;
		end else begin
			case (state)
				dpw_pkg::ST_ADDR, dpw_pkg::ST_CMD, dpw_pkg::ST_WDATA: begin
					if (scl_rise) begin
						next_shift   = {shift[6:0], pins[dpw_pkg::SYNC_SDA]};
						next_bit_cnt = bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == dpw_pkg::BITS_PER_BYTE) begin
						next_bit_cnt = 4'h0;
						if (state == dpw_pkg::ST_ADDR) begin
							next_state     = addr_match ? dpw_pkg::ST_ADDR_ACK
								: dpw_pkg::ST_IDLE;
							next_drive_low = addr_match;
							next_cmd       = shift; // Direction kept in bit 0
						end else if (state == dpw_pkg::ST_CMD) begin
							if (shift == dpw_pkg::CMD_WR_STORE || shift == dpw_pkg::CMD_WR_WIPER
								|| shift == dpw_pkg::CMD_WR_BOTH) begin
								next_state     = dpw_pkg::ST_CMD_ACK;
								next_drive_low = 1'b1;
								next_cmd       = shift;
							end else begin
								next_state = dpw_pkg::ST_IDLE;
							end
						end else begin
							// Write data lands in the register(s) the command names
							if (cmd != dpw_pkg::CMD_WR_WIPER) begin
								next_storage = shift;
							end
							if (cmd != dpw_pkg::CMD_WR_STORE) begin
								next_wiper = shift;
							end
							next_state     = dpw_pkg::ST_WDATA_ACK;
							next_drive_low = 1'b1;
						end
					end
				end
				dpw_pkg::ST_ADDR_ACK: begin
					if (scl_fall) begin
						next_bit_cnt = 4'h0;
						if (cmd[dpw_pkg::DIR_BIT]) begin
							// Read: storage byte goes out first
							next_state     = dpw_pkg::ST_RDATA;
							next_rd_second = 1'b0;
							next_shift     = storage_out;
							next_drive_low = !storage_out[7];
						end else begin
							next_state     = dpw_pkg::ST_CMD;
							next_drive_low = 1'b0;
						end
					end
				end
				dpw_pkg::ST_CMD_ACK: begin
					if (scl_fall) begin
						next_state     = dpw_pkg::ST_WDATA;
						next_drive_low = 1'b0;
					end
				end
				dpw_pkg::ST_WDATA_ACK: begin
					if (scl_fall) begin
						next_state     = dpw_pkg::ST_IDLE;
						next_drive_low = 1'b0;
					end
				end
				dpw_pkg::ST_RDATA: begin
					if (scl_rise) begin
						next_bit_cnt = bit_cnt + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt == dpw_pkg::BITS_PER_BYTE) begin
							next_state     = dpw_pkg::ST_RACK;
							next_drive_low = 1'b0;
						end else begin
							next_shift     = {shift[6:0], 1'b1};
							next_drive_low = !shift[6];
						end
					end
				end
				dpw_pkg::ST_RACK: begin
					if (scl_rise) begin
						next_master_ack = !pins[dpw_pkg::SYNC_SDA];
					end else if (scl_fall) begin
						if (master_ack && !rd_second) begin
							// Second byte is the live wiper value
							next_state     = dpw_pkg::ST_RDATA;
							next_rd_second = 1'b1;
							next_bit_cnt   = 4'h0;
							next_shift     = wiper_out;
							next_drive_low = !wiper_out[7];
						end else begin
							next_state = dpw_pkg::ST_IDLE;
						end
					end
				end
				dpw_pkg::ST_IDLE: begin
					next_drive_low = 1'b0;
				end
				default: begin
					next_state     = dpw_pkg::ST_IDLE;
					next_drive_low = 1'b0;
				end
			endcase
		end
	end

	// State and register storage; power-up clears both bytes
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state          <= dpw_pkg::ST_IDLE;
			bit_cnt        <= 4'h0;
			shift          <= 8'h00;
			cmd            <= 8'h00;
			drive_low      <= 1'b0;
			rd_second      <= 1'b0;
			master_ack     <= 1'b0;
			scl_q          <= 1'b1;
			sda_q          <= 1'b1;
			storage_out    <= dpw_pkg::STORE_RESET;
			wiper_out      <= dpw_pkg::WIPER_RESET;
			tap_select_out <= {{(dpw_pkg::TAP_COUNT-1){1'b0}}, 1'b1};
		end else begin
			state          <= next_state;
			bit_cnt        <= next_bit_cnt;
			shift          <= next_shift;
			cmd            <= next_cmd;
			drive_low      <= next_drive_low;
			rd_second      <= next_rd_second;
			master_ack     <= next_master_ack;
			scl_q          <= pins[dpw_pkg::SYNC_SCL];
			sda_q          <= pins[dpw_pkg::SYNC_SDA];
			storage_out    <= next_storage;
			wiper_out      <= next_wiper;
			tap_select_out <= next_tap;
		end
	end

	// Open-drain data pin: value always low, enable active low
	always_comb begin
		sda_out         = 1'b0;
		sda_drive_n_out = !drive_low;
	end
endmodule

// >>> src/dpw_unused_placeholder_none.sv
// Intentionally empty companion; no logic.
`timescale 1ns/1ns

// >>> sim/dpw_wiper_regs_asserts.sv
// Checker for the wiper register bank ports.
// Assumes it is bound to every dpw_wiper_regs instance.
`timescale 1ns/1ns
module dpw_wiper_regs_asserts (
	input wire logic		clock_in,	// System clock
	input wire logic		rst_in,		// Reset
	input wire logic		scl_in,		// Bus clock
	input wire logic		sda_in,		// Data wire
	input wire logic		sda_out,	// Driven value
	input wire logic		sda_drive_n_out,// Drive, low
	input wire logic		addr_select_bit0,// Select 0
	input wire logic		addr_select_bit1,// Select 1
	input wire logic		addr_select_bit2,// Select 2
	input wire logic [7:0]	storage_out,	// Storage byte
	input wire logic [7:0]	wiper_out,	// Wiper byte
	input wire logic [255:0]	tap_select_out	// Tap vector
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	// ------------------------------------------------------------
	// Data pin value, tap decode and reset values
	// ------------------------------------------------------------
	AST_SDA_LOW: assert property (sda_out == 1'b0)
		else $error("sda value not low");
	AST_ONE_TAP: assert property ($onehot(tap_select_out))
		else $error("tap not one-hot");
	AST_TAP_FOLLOW: assert property (tap_select_out[wiper_out] == 1'b1)
		else $error("tap not at wiper");
	AST_TAP_LOW: assert property (wiper_out == 8'h00 |-> tap_select_out[0])
		else $error("low tap wrong");
	AST_TAP_HIGH: assert property (wiper_out == 8'hff |-> tap_select_out[255])
		else $error("high tap wrong");
	AST_WIPER_INIT: assert property ($fell(rst_in) |-> wiper_out == 8'h00)
		else $error("wiper not cleared");
	AST_STORE_INIT: assert property ($fell(rst_in) |-> storage_out == 8'h00)
		else $error("storage not cleared");
	// ------------------------------------------------------------
	// Register updates come with an acknowledge; drive changes only while scl is low
	// ------------------------------------------------------------
	AST_WIPER_ACKED: assert property ($changed(wiper_out) |-> ##[0:2] !sda_drive_n_out)
		else $error("wiper change without ack");
	AST_STORE_ACKED: assert property ($changed(storage_out) |-> ##[0:2] !sda_drive_n_out)
		else $error("storage change without ack");
	AST_DRIVE_SCL_LOW: assert property ($changed(sda_drive_n_out) |-> !scl_in)
		else $error("sda drive changed while scl high");
	cover property (wiper_out == 8'hff);
	cover property ($changed(storage_out));
	cover property ($fell(sda_drive_n_out));
endmodule
bind dpw_wiper_regs dpw_wiper_regs_asserts chk (.clock_in(clock_in), .rst_in(rst_in),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_drive_n_out(sda_drive_n_out),
	.addr_select_bit0(addr_select_bit0), .addr_select_bit1(addr_select_bit1),
	.addr_select_bit2(addr_select_bit2), .storage_out(storage_out), .wiper_out(wiper_out),
	.tap_select_out(tap_select_out));

// >>> sim/dpw_bus_master.sv
// Behavioural 2-wire bus master facing the wiper register bank.
// Assumes a 25 MHz pacing clock; one bus bit spans 8 cycles (320 ns).
`timescale 1ns/1ns
module dpw_bus_master (
	input  wire logic	clock_in,	// Pacing clock
	input  wire logic	sda_in,		// Resolved data wire
	output logic		scl_out,	// Bus clock, idles high
	output logic		sda_out		// Data level, 1 releases
);
	// Bus idles released
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// Wait n cycles, then step just past the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
		#2;
	endtask
	// One bit: data set early in the low phase, sampled just before the fall
	task automatic bitx(input logic b, output logic r);
		tick(1);
		sda_out = b;
		tick(5);
		scl_out = 1'b1;
		tick(2);
		r = sda_in;
		scl_out = 1'b0;
	endtask
	// Start: data falls while the clock is high
	task automatic start();
		tick(6);
		sda_out = 1'b1;
		tick(2);
		scl_out = 1'b1;
		tick(4);
		sda_out = 1'b0;
		tick(4);
		scl_out = 1'b0;
	endtask
	// Stop: data rises while the clock is high, clock then stands still
	task automatic stop();
		tick(6);
		sda_out = 1'b0;
		tick(2);
		scl_out = 1'b1;
		tick(4);
		sda_out = 1'b1;
		tick(8);
	endtask
	// Send a byte and return the acknowledge
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(b[i], r);
		bitx(1'b1, r);
		ack = ~r;
	endtask
	// Receive a byte; last releases the ninth bit as a nack
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(1'b1, d[i]);
		bitx(last, r);
	endtask
endmodule

// >>> sim/dpw_wiper_regs_tb_top.sv
// Bench for the wiper register bank, driven by a bus master model.
// Assumes the master model and the checker are compiled first.
`timescale 1ns/1ns
module dpw_wiper_regs_tb_top;
	logic		clock_in = 1'b0;// System clock
	logic		rst_in = 1'b1;	// Reset
	logic [2:0]	sel = 3'h5;	// Select pins
	logic		scl;		// Bus clock
	logic		m_sda;		// Master data level
	logic		dval;		// Device data value
	logic		drv_n;		// Device drive, low
	logic [7:0]	stor;		// Storage byte
	logic [7:0]	wip;		// Wiper byte
	logic [255:0]	tap;		// Tap vector
	logic [7:0]	s;		// Read storage
	logic [7:0]	w;		// Read wiper
	logic		a;		// Acknowledge
	int		n_mismatch = 0;	// Mismatches
	int		checked = 0;	// Comparisons
	int		cycles = 0;	// Timeout count
	wire		sda = m_sda & (drv_n | dval); // Wired-and with pull-up
	always #20 clock_in = ~clock_in;
	dpw_bus_master m (.clock_in(clock_in), .sda_in(sda), .scl_out(scl), .sda_out(m_sda));
	dpw_wiper_regs dut (.clock_in(clock_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
		.sda_out(dval), .sda_drive_n_out(drv_n), .addr_select_bit0(sel[0]),
		.addr_select_bit1(sel[1]), .addr_select_bit2(sel[2]), .storage_out(stor),
		.wiper_out(wip), .tap_select_out(tap));
	// ------------------------------------------------------------
	// Compare and report
	// ------------------------------------------------------------
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic results();
		$display("Comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Cut a hang short
	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			results();
		end
	end
	// ------------------------------------------------------------
	// Transfers and scenarios
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
		m.start();
		m.wbyte({dpw_pkg::CTRL_CODE, sel, 1'b0}, a);
		chk1("ack_ctl", 1'b1, a);
		m.wbyte(cmd, a);
		chk1("ack_cmd", 1'b1, a);
		m.wbyte(d, a);
		chk1("ack_dat", 1'b1, a);
		m.stop();
	endtask
	task automatic s_wiper();
		wr(dpw_pkg::CMD_WR_WIPER, 8'hff);
		chk8("wiper", 8'hff, wip);
		chk1("tap_top", 1'b1, tap[255]);
		chk8("storage", 8'h00, stor);
	endtask
	task automatic s_store();
		wr(dpw_pkg::CMD_WR_STORE, 8'h3c);
		chk8("storage", 8'h3c, stor);
		chk8("wiper", 8'hff, wip);
	endtask
	task automatic s_read(input logic [7:0] es, input logic [7:0] ew);
		m.start();
		m.wbyte({dpw_pkg::CTRL_CODE, sel, 1'b1}, a);
		chk1("ack_rd", 1'b1, a);
		m.rbyte(1'b0, s);
		m.rbyte(1'b1, w);
		m.stop();
		chk8("rd_storage", es, s);
		chk8("rd_wiper", ew, w);
	endtask
	task automatic s_both_short();
		wr(dpw_pkg::CMD_WR_BOTH, 8'h81);
		chk8("wiper", 8'h81, wip);
		m.start();
		m.wbyte({dpw_pkg::CTRL_CODE, sel, 1'b1}, a);
		chk1("ack_rd", 1'b1, a);
		m.rbyte(1'b1, s);
		m.stop();
		chk8("rd_first", 8'h81, s);
		chk8("storage", 8'h81, stor);
	endtask
	task automatic s_refuse();
		m.start();
		m.wbyte({dpw_pkg::CTRL_CODE, ~sel, 1'b0}, a);
		chk1("ack_sel", 1'b0, a);
		m.stop();
		m.start();
		m.wbyte({4'h6, sel, 1'b0}, a);
		chk1("ack_code", 1'b0, a);
		m.stop();
		chk8("wiper", 8'h81, wip);
	endtask
	// Unknown command refused, extra write byte refused
	task automatic s_bad_cmd();
		m.start();
		m.wbyte({dpw_pkg::CTRL_CODE, sel, 1'b0}, a);
		chk1("ack_ctl", 1'b1, a);
		m.wbyte(8'h55, a);
		chk1("ack_badcmd", 1'b0, a);
		m.stop();
		m.start();
		m.wbyte({dpw_pkg::CTRL_CODE, sel, 1'b0}, a);
		m.wbyte(dpw_pkg::CMD_WR_WIPER, a);
		m.wbyte(8'h42, a);
		chk1("ack_dat", 1'b1, a);
		m.wbyte(8'h99, a);
		chk1("ack_extra", 1'b0, a);
		m.stop();
		chk8("wiper", 8'h42, wip);
		chk1("tap_mid", 1'b1, tap[8'h42]);
		chk8("storage", 8'h81, stor);
	endtask
	// Reset in mid-run clears both bytes, then a read sees zeros
	task automatic s_reset();
		m.tick(1);
		rst_in = 1'b1;
		m.tick(2);
		rst_in = 1'b0;
		m.tick(8);
		chk8("storage", 8'h00, stor);
		chk8("wiper", 8'h00, wip);
		chk1("tap_low", 1'b1, tap[0]);
		s_read(8'h00, 8'h00);
	endtask
	// Main sequence
	initial begin
		repeat (16) @(posedge clock_in);
		#2 rst_in = 1'b0;
		m.tick(8);
		chk8("storage", 8'h00, stor);
		chk8("wiper", 8'h00, wip);
		chk1("tap_low", 1'b1, tap[0]);
		s_wiper();
		s_store();
		s_read(8'h3c, 8'hff);
		s_both_short();
		s_refuse();
		s_bad_cmd();
		s_reset();
		results();
	end
endmodule
